// ===== include/mbc_pkg.sv
// Constants and types shared by the measurement broadcast register bank
package mbc_pkg;

  // ****************************************************************
  // Bus geometry and register offsets
  // ****************************************************************
  localparam int          ADDR_W    = 16;
  localparam int          DATA_W    = 16;
  localparam logic [15:0] ADDR_PER  = 16'h1402;
  localparam logic [15:0] ADDR_SYNC = 16'h1403;
  localparam logic [15:0] ADDR_CELL = 16'h1408;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int PER_CTRL_BIT   = 12;
  localparam int PER_LEN_LSB    = 0;
  localparam int PER_LEN_W      = 9;
  localparam int SYNC_PAUSE_BIT = 15;
  localparam int SYNC_OVL_LSB   = 10;
  localparam int OVL_W          = 5;
  localparam int SYNC_FAST_BIT  = 1;
  localparam int SYNC_CYC_BIT   = 0;
  localparam int CELL_N         = 16;

  // Defined bits of each word; everything else is reserved
  localparam logic [15:0] PER_USED_MASK  = 16'h11FF;
  localparam logic [15:0] SYNC_USED_MASK = 16'hFC03;
  localparam logic [15:0] CELL_USED_MASK = 16'hFFFF;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [8:0]  RST_PER_LEN  = 9'h010;
  localparam logic [4:0]  RST_OVL      = 5'h1F;
  localparam logic        RST_BIT      = 1'h0;
  localparam logic [15:0] RST_CELL_EN  = 16'h0000;
  localparam logic [15:0] RST_DATA     = 16'h0000;

  // ****************************************************************
  // Decoded register selection
  // ****************************************************************
  typedef enum logic [1:0] {
    REG_NONE,
    REG_PER,
    REG_SYNC,
    REG_CELL
  } mbc_sel_e;

endpackage

// ===== include/mbc_wr_if.sv
// Decoded broadcast write carried from the bank front end to each chain copy
`timescale 1ns/1ns
`default_nettype none
interface mbc_wr_if;
  logic                 ce;
  mbc_pkg::mbc_sel_e    sel;
  logic [15:0]          data;

  modport src (output ce, output sel, output data);
  modport dst (input  ce, input  sel, input  data);
endinterface
`default_nettype wire

// ===== verilog/mbc_chain_copy.sv
// One measurement chain's copy of the broadcast control fields
`timescale 1ns/1ns
`default_nettype none
module mbc_chain_copy #(
  parameter bit SECONDARY = 1'b0,
  parameter int CELLS     = mbc_pkg::CELL_N
) (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  mbc_wr_if.dst                 wr,
  output logic                  o_periodic_control_bit,
  output logic [8:0]            o_period_length,
  output logic                  o_balancing_pause_request,
  output logic                  o_synchronous_cycle_bit,
  output logic [CELLS-1:0]      o_cell_enable,
  output logic [4:0]            o_secondary_overlap_count,
  output logic                  o_fast_secondary_measure,
  output logic                  o_dummy_fast_cycle
);

  // ****************************************************************
  // Fields common to both chains
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_periodic_control_bit <= mbc_pkg::RST_BIT;
      o_period_length        <= mbc_pkg::RST_PER_LEN;
    end
    else if (wr.ce && wr.sel == mbc_pkg::REG_PER)
    begin
      o_periodic_control_bit <= wr.data[mbc_pkg::PER_CTRL_BIT];                   // [R1]
      o_period_length        <= wr.data[mbc_pkg::PER_LEN_LSB +: mbc_pkg::PER_LEN_W]; // [R2]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_balancing_pause_request <= mbc_pkg::RST_BIT;
      o_synchronous_cycle_bit   <= mbc_pkg::RST_BIT;
    end
    else if (wr.ce && wr.sel == mbc_pkg::REG_SYNC)
    begin
      o_balancing_pause_request <= wr.data[mbc_pkg::SYNC_PAUSE_BIT]; // [R4]
      o_synchronous_cycle_bit   <= wr.data[mbc_pkg::SYNC_CYC_BIT];   // [R7]
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      o_cell_enable <= CELLS'(mbc_pkg::RST_CELL_EN);
    else if (wr.ce && wr.sel == mbc_pkg::REG_CELL)
      o_cell_enable <= wr.data[CELLS-1:0]; // [R8]
  end

  // ****************************************************************
  // Chain specific fields
  // ****************************************************************
  generate
    if (SECONDARY)
    begin : g_sec
      always_ff @(posedge i_clock or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          o_secondary_overlap_count <= mbc_pkg::RST_OVL;
          o_fast_secondary_measure  <= mbc_pkg::RST_BIT;
        end
        else if (wr.ce && wr.sel == mbc_pkg::REG_SYNC)
        begin
          o_secondary_overlap_count <= wr.data[mbc_pkg::SYNC_OVL_LSB +: mbc_pkg::OVL_W]; // [R5]
          o_fast_secondary_measure  <= wr.data[mbc_pkg::SYNC_FAST_BIT];                  // [R6]
        end
      end
      assign o_dummy_fast_cycle = 1'b0;
    end
    else
    begin : g_pri
      // Primary has no overlap or fast field; the fast bit only kicks a dummy cycle
      assign o_secondary_overlap_count = mbc_pkg::RST_OVL; // [R5]
      assign o_fast_secondary_measure  = mbc_pkg::RST_BIT;
      always_ff @(posedge i_clock or negedge i_resetn)
      begin
        if (!i_resetn)
          o_dummy_fast_cycle <= 1'b0;
        else if (wr.ce)
          o_dummy_fast_cycle <= (wr.sel == mbc_pkg::REG_SYNC) &&
                                wr.data[mbc_pkg::SYNC_FAST_BIT]; // [R6]
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== verilog/mbc_bcast_bank.sv
// Write-only broadcast register bank feeding the primary and secondary chains
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] Periodic control bit 12 is copied to both chains on write.
// [R2] Nine-bit period length, reset 10h, is copied to both chains on write.
// [R3] Reserved bits of the broadcast words are dropped and never take effect.
// [R4] Balancing pause request bit 15 goes to both chains; resets to zero.
// [R5] Overlap count bits 14:10, reset 1Fh, reach only the secondary chain.
// [R6] Fast bit writes the secondary field and only pulses a primary dummy cycle.
// [R7] Synchronous cycle bit 0 goes to both chains on write; resets to zero.
// [R8] Each cell enable bit n sets both chains' cell n enable alike.
// [R9] All three words are write-only; there is no read path.
// [R10] One write updates both chains on the same edge, never a mixture.
module mbc_bcast_bank #(
  parameter int CELLS = mbc_pkg::CELL_N
) (
  input  wire logic             I_CLOCK,
  input  wire logic             I_RESETN,
  input  wire logic             I_CLK_EN,
  input  wire logic             I_WR_EN,
  input  wire logic [15:0]      I_WR_ADDR,
  input  wire logic [15:0]      I_WR_DATA,
  output logic                  O_WR_ACK,
  output logic                  O_WR_UNMAPPED,
  output logic                  O_PRI_PERIODIC_CONTROL_BIT,
  output logic [8:0]            O_PRI_PERIOD_LENGTH,
  output logic                  O_PRI_BALANCING_PAUSE_REQUEST,
  output logic                  O_PRI_SYNCHRONOUS_CYCLE_BIT,
  output logic                  O_PRI_DUMMY_FAST_CYCLE,
  output logic [CELLS-1:0]      O_PRI_CELL_ENABLE,
  output logic                  O_SEC_PERIODIC_CONTROL_BIT,
  output logic [8:0]            O_SEC_PERIOD_LENGTH,
  output logic                  O_SEC_BALANCING_PAUSE_REQUEST,
  output logic                  O_SEC_SYNCHRONOUS_CYCLE_BIT,
  output logic [4:0]            O_SEC_OVERLAP_COUNT,
  output logic                  O_SEC_FAST_MEASURE,
  output logic [CELLS-1:0]      O_SEC_CELL_ENABLE
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  mbc_pkg::mbc_sel_e sel_d;
  mbc_pkg::mbc_sel_e sel_q;
  logic [15:0]       data_d;
  logic [15:0]       data_q;
  logic              bad_q;

  always_comb
  begin
    sel_d  = mbc_pkg::REG_NONE;
    data_d = mbc_pkg::RST_DATA;
    if (I_WR_EN)
    begin
      if (I_WR_ADDR == mbc_pkg::ADDR_PER)
        sel_d = mbc_pkg::REG_PER;
      else if (I_WR_ADDR == mbc_pkg::ADDR_SYNC)
        sel_d = mbc_pkg::REG_SYNC;
      else if (I_WR_ADDR == mbc_pkg::ADDR_CELL)
        sel_d = mbc_pkg::REG_CELL;
    end
    // Reserved bits are zeroed here so no chain ever sees them
    unique case (sel_d)
      mbc_pkg::REG_PER:  data_d = I_WR_DATA & mbc_pkg::PER_USED_MASK;  // [R3]
      mbc_pkg::REG_SYNC: data_d = I_WR_DATA & mbc_pkg::SYNC_USED_MASK; // [R3]
      mbc_pkg::REG_CELL: data_d = I_WR_DATA & mbc_pkg::CELL_USED_MASK;
      mbc_pkg::REG_NONE: data_d = mbc_pkg::RST_DATA;
    endcase
  end

  // ****************************************************************
  // Write stage
  // ****************************************************************
  // One registered stage feeds both chains from the same flops, so the
  // primary and secondary copies change on one edge. Nothing is stored
  // for reading back: besides this stage and the status flops, only the chain copies hold state.
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      sel_q  <= mbc_pkg::REG_NONE;
      data_q <= mbc_pkg::RST_DATA;
    end
    else if (I_CLK_EN)
    begin
      sel_q  <= sel_d;  // [R10]
      data_q <= data_d; // [R9]
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      bad_q         <= 1'b0;
      O_WR_ACK      <= 1'b0;
      O_WR_UNMAPPED <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      bad_q         <= I_WR_EN && (sel_d == mbc_pkg::REG_NONE);
      O_WR_ACK      <= (sel_q != mbc_pkg::REG_NONE);
      O_WR_UNMAPPED <= bad_q;
    end
  end

  // ****************************************************************
  // Chain copies
  // ****************************************************************
  mbc_wr_if wr_bus ();

  assign wr_bus.ce   = I_CLK_EN;
  assign wr_bus.sel  = sel_q;
  assign wr_bus.data = data_q;

  mbc_chain_copy #(
    .SECONDARY (1'b0),
    .CELLS     (CELLS)
  ) u_primary (
    .i_clock                   (I_CLOCK),
    .i_resetn                  (I_RESETN),
    .wr                        (wr_bus.dst),
    .o_periodic_control_bit    (O_PRI_PERIODIC_CONTROL_BIT),
    .o_period_length           (O_PRI_PERIOD_LENGTH),
    .o_balancing_pause_request (O_PRI_BALANCING_PAUSE_REQUEST),
    .o_synchronous_cycle_bit   (O_PRI_SYNCHRONOUS_CYCLE_BIT),
    .o_cell_enable             (O_PRI_CELL_ENABLE),
    .o_secondary_overlap_count (),
    .o_fast_secondary_measure  (),
    .o_dummy_fast_cycle        (O_PRI_DUMMY_FAST_CYCLE)
  );

  mbc_chain_copy #(
    .SECONDARY (1'b1),
    .CELLS     (CELLS)
  ) u_secondary (
    .i_clock                   (I_CLOCK),
    .i_resetn                  (I_RESETN),
    .wr                        (wr_bus.dst),
    .o_periodic_control_bit    (O_SEC_PERIODIC_CONTROL_BIT),
    .o_period_length           (O_SEC_PERIOD_LENGTH),
    .o_balancing_pause_request (O_SEC_BALANCING_PAUSE_REQUEST),
    .o_synchronous_cycle_bit   (O_SEC_SYNCHRONOUS_CYCLE_BIT),
    .o_cell_enable             (O_SEC_CELL_ENABLE),
    .o_secondary_overlap_count (O_SEC_OVERLAP_COUNT),
    .o_fast_secondary_measure  (O_SEC_FAST_MEASURE),
    .o_dummy_fast_cycle        ()
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_wr(logic [15:0] a);
    I_CLK_EN && I_WR_EN && (I_WR_ADDR == a) ##1 I_CLK_EN;
  endsequence

  a_per_ctrl_fanout: assert property ( // [R1]
    s_wr(mbc_pkg::ADDR_PER) |=>
      O_PRI_PERIODIC_CONTROL_BIT == $past(I_WR_DATA[12], 2) &&
      O_SEC_PERIODIC_CONTROL_BIT == $past(I_WR_DATA[12], 2))
    else $error("periodic control bit not copied to both chains");

  a_per_len_fanout: assert property ( // [R2]
    s_wr(mbc_pkg::ADDR_PER) |=>
      O_PRI_PERIOD_LENGTH == $past(I_WR_DATA[8:0], 2) &&
      O_SEC_PERIOD_LENGTH == $past(I_WR_DATA[8:0], 2))
    else $error("period length not copied to both chains");

  a_reserved_inert: assert property ( // [R3]
    s_wr(mbc_pkg::ADDR_SYNC) |=>
      O_SEC_BALANCING_PAUSE_REQUEST == $past(I_WR_DATA[15], 2) &&
      O_SEC_OVERLAP_COUNT == $past(I_WR_DATA[14:10], 2) &&
      O_SEC_FAST_MEASURE == $past(I_WR_DATA[1], 2) &&
      O_SEC_SYNCHRONOUS_CYCLE_BIT == $past(I_WR_DATA[0], 2))
    else $error("reserved sync bits disturbed a field");

  a_pause_fanout: assert property ( // [R4]
    s_wr(mbc_pkg::ADDR_SYNC) |=>
      O_PRI_BALANCING_PAUSE_REQUEST == $past(I_WR_DATA[15], 2) &&
      O_SEC_BALANCING_PAUSE_REQUEST == O_PRI_BALANCING_PAUSE_REQUEST)
    else $error("pause request not copied to both chains");

  a_overlap_secondary: assert property ( // [R5]
    s_wr(mbc_pkg::ADDR_SYNC) |=>
      O_SEC_OVERLAP_COUNT == $past(I_WR_DATA[14:10], 2) &&
      $stable(O_PRI_PERIOD_LENGTH) && $stable(O_PRI_CELL_ENABLE))
    else $error("overlap count write misrouted");

  a_fast_dummy: assert property ( // [R6]
    s_wr(mbc_pkg::ADDR_SYNC) |=>
      O_PRI_DUMMY_FAST_CYCLE == $past(I_WR_DATA[1], 2) &&
      O_SEC_FAST_MEASURE == $past(I_WR_DATA[1], 2))
    else $error("fast bit handling wrong");

  a_dummy_source: assert property ( // [R6]
    $rose(O_PRI_DUMMY_FAST_CYCLE) |-> $past(sel_q) == mbc_pkg::REG_SYNC)
    else $error("dummy fast cycle without sync write");

  a_sync_cycle: assert property ( // [R7]
    s_wr(mbc_pkg::ADDR_SYNC) |=>
      O_PRI_SYNCHRONOUS_CYCLE_BIT == $past(I_WR_DATA[0], 2) &&
      O_SEC_SYNCHRONOUS_CYCLE_BIT == $past(I_WR_DATA[0], 2))
    else $error("sync cycle bit not copied to both chains");

  a_cell_fanout: assert property ( // [R8]
    s_wr(mbc_pkg::ADDR_CELL) |=>
      O_PRI_CELL_ENABLE == $past(I_WR_DATA[CELLS-1:0], 2) &&
      O_SEC_CELL_ENABLE == $past(I_WR_DATA[CELLS-1:0], 2))
    else $error("cell enables not copied to both chains");

  a_hold_no_write: assert property ( // [R9]
    !(I_CLK_EN && sel_q == mbc_pkg::REG_CELL) |=> $stable(O_PRI_CELL_ENABLE))
    else $error("cell enable changed without a write");

  a_chains_match: assert property ( // [R10]
    O_PRI_CELL_ENABLE == O_SEC_CELL_ENABLE &&
    O_PRI_PERIOD_LENGTH == O_SEC_PERIOD_LENGTH &&
    O_PRI_PERIODIC_CONTROL_BIT == O_SEC_PERIODIC_CONTROL_BIT &&
    O_PRI_SYNCHRONOUS_CYCLE_BIT == O_SEC_SYNCHRONOUS_CYCLE_BIT)
    else $error("chain copies disagree");

  a_ack_timing: assert property (
    I_CLK_EN && I_WR_EN && sel_d != mbc_pkg::REG_NONE ##1 I_CLK_EN |=> O_WR_ACK)
    else $error("write not acknowledged after two cycles");

  // ****************************************************************
  // Reserved bits never reach the chains
  // ****************************************************************
  // Checked at the write stage, not at the chain outputs: the chains
  // pick only defined bits and would hide a broken mask.
  a_per_reserved_zero: assert property ( // [R3]
    sel_q == mbc_pkg::REG_PER |-> (data_q & ~mbc_pkg::PER_USED_MASK) == 16'h0000)
    else $error("reserved periodic bits reached the write stage");

  a_sync_reserved_zero: assert property ( // [R3]
    sel_q == mbc_pkg::REG_SYNC |-> (data_q & ~mbc_pkg::SYNC_USED_MASK) == 16'h0000)
    else $error("reserved sync bits reached the write stage");

  a_idle_stage_clear: assert property ( // [R9]
    sel_q == mbc_pkg::REG_NONE |-> data_q == mbc_pkg::RST_DATA)
    else $error("write stage holds data without a mapped write");

  // ****************************************************************
  // Reset values and fields that only a write may move
  // ****************************************************************
  // Sampled at the first edge after release, before any write can land
  a_reset_values: assert property ( // [R2][R5]
    $rose(I_RESETN) |->
      O_PRI_PERIOD_LENGTH == mbc_pkg::RST_PER_LEN &&
      O_SEC_PERIOD_LENGTH == mbc_pkg::RST_PER_LEN &&
      O_SEC_OVERLAP_COUNT == mbc_pkg::RST_OVL &&
      O_PRI_BALANCING_PAUSE_REQUEST == mbc_pkg::RST_BIT &&
      O_SEC_SYNCHRONOUS_CYCLE_BIT == mbc_pkg::RST_BIT &&
      O_PRI_CELL_ENABLE == CELLS'(mbc_pkg::RST_CELL_EN) &&
      !O_WR_ACK && !O_WR_UNMAPPED)
    else $error("outputs not at reset values after reset");

  a_period_hold: assert property ( // [R2]
    !(I_CLK_EN && sel_q == mbc_pkg::REG_PER) |=>
      $stable(O_PRI_PERIOD_LENGTH) && $stable(O_SEC_PERIOD_LENGTH) &&
      $stable(O_PRI_PERIODIC_CONTROL_BIT))
    else $error("period fields moved without a periodic write");

  a_overlap_hold: assert property ( // [R5]
    !(I_CLK_EN && sel_q == mbc_pkg::REG_SYNC) |=>
      $stable(O_SEC_OVERLAP_COUNT) && $stable(O_SEC_FAST_MEASURE) &&
      $stable(O_PRI_BALANCING_PAUSE_REQUEST))
    else $error("sync fields moved without a sync write");

  a_sec_cell_hold: assert property ( // [R8]
    !(I_CLK_EN && sel_q == mbc_pkg::REG_CELL) |=> $stable(O_SEC_CELL_ENABLE))
    else $error("secondary cell enable changed without a write");

  // ****************************************************************
  // Clock enable and status pulses
  // ****************************************************************
  // Pulses hold too: a frozen cycle must not swallow an acknowledge
  a_enable_freeze: assert property (
    !I_CLK_EN |=>
      $stable(O_WR_ACK) && $stable(O_WR_UNMAPPED) &&
      $stable(O_PRI_DUMMY_FAST_CYCLE) && $stable(O_PRI_CELL_ENABLE) &&
      $stable(O_SEC_OVERLAP_COUNT) && $stable(O_SEC_PERIOD_LENGTH))
    else $error("state moved while the clock enable was low");

  a_unmapped_flag: assert property (
    I_CLK_EN && I_WR_EN && sel_d == mbc_pkg::REG_NONE ##1 I_CLK_EN |=>
      O_WR_UNMAPPED && !O_WR_ACK)
    else $error("unmapped write not flagged");

  a_pulse_drop: assert property ( // [R6]
    I_CLK_EN && !I_WR_EN ##1 I_CLK_EN |=>
      !O_PRI_DUMMY_FAST_CYCLE && !O_WR_ACK && !O_WR_UNMAPPED)
    else $error("status pulse outlived its write");

  c_per_write:  cover property (s_wr(mbc_pkg::ADDR_PER) ##1 O_WR_ACK);
  c_fast_pulse: cover property (O_PRI_DUMMY_FAST_CYCLE && O_SEC_FAST_MEASURE);
  c_cell_write: cover property (s_wr(mbc_pkg::ADDR_CELL) ##1 O_PRI_CELL_ENABLE != 16'h0000);
  c_unmapped:   cover property (O_WR_UNMAPPED);
  c_sync_write: cover property (s_wr(mbc_pkg::ADDR_SYNC) ##1 O_SEC_OVERLAP_COUNT != 5'h1F);

endmodule
`default_nettype wire

// ===== dv/mbc_chain_model.sv
// Far-side model: expected chain copies rebuilt from the host write stream
`timescale 1ns/1ns
`default_nettype none
module mbc_chain_model (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_data,
  output logic             o_ack,
  output logic             o_unm,
  output logic             o_pc,
  output logic [8:0]       o_len,
  output logic             o_pause,
  output logic             o_cyc,
  output logic [4:0]       o_ovl,
  output logic             o_fast,
  output logic             o_dummy,
  output logic [15:0]      o_cell
);
  logic        v_q;
  logic [15:0] a_q;
  logic [15:0] d_q;
  logic        hit;

  assign hit = (a_q == mbc_pkg::ADDR_PER) || (a_q == mbc_pkg::ADDR_SYNC)
             || (a_q == mbc_pkg::ADDR_CELL);

  // ****************************************************************
  // Capture stage, frozen with the clock enable like the bank
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      v_q <= 1'b0;
      a_q <= 16'h0000;
      d_q <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      v_q <= i_wr_en;
      a_q <= i_addr;
      d_q <= i_data;
    end
  end

  // ****************************************************************
  // Chain copies; one write moves its own register's fields in both chains at once
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_ack   <= 1'b0;
      o_unm   <= 1'b0;
      o_dummy <= 1'b0;
      o_pc    <= 1'b0;
      o_len   <= 9'h010;
      o_pause <= 1'b0;
      o_ovl   <= 5'h1F;
      o_fast  <= 1'b0;
      o_cyc   <= 1'b0;
      o_cell  <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      o_ack   <= v_q && hit;
      o_unm   <= v_q && !hit;
      o_dummy <= v_q && (a_q == mbc_pkg::ADDR_SYNC) && d_q[1];
      if (v_q && (a_q == mbc_pkg::ADDR_PER))
      begin
        o_pc  <= d_q[12];
        o_len <= d_q[8:0];
      end
      if (v_q && (a_q == mbc_pkg::ADDR_SYNC))
      begin
        o_pause <= d_q[15];
        o_ovl   <= d_q[14:10];
        o_fast  <= d_q[1];
        o_cyc   <= d_q[0];
      end
      if (v_q && (a_q == mbc_pkg::ADDR_CELL))
        o_cell <= d_q;
    end
  end
endmodule
`default_nettype wire

// ===== dv/measurement_broadcast_config_bench.sv
// Self-checking bench: bank outputs against the chain model every cycle
`timescale 1ns/1ns
`default_nettype none
module measurement_broadcast_config_bench;
  logic        clk = 1'b0;
  logic        rst_n, clk_en, wr_en, ack, unm, m_ack, m_unm;
  logic [15:0] addr, data, p_cell, s_cell, m_cell;
  logic        p_pc, p_pause, p_cyc, p_dum, s_pc, s_pause, s_cyc, s_fast;
  logic        m_pc, m_pause, m_cyc, m_fast, m_dum;
  logic [8:0]  p_len, s_len, m_len;
  logic [4:0]  s_ovl, m_ovl;
  logic [31:0] r;
  logic [15:0] seq_a [9] = '{16'h1402, 16'h1403, 16'h1408, 16'h1403, 16'h1402,
                             16'h1409, 16'h1401, 16'h1408, 16'h1403};
  logic [15:0] seq_d [9] = '{16'hFFFF, 16'hFFFF, 16'h8001, 16'h0000, 16'h0000,
                             16'hFFFF, 16'hFFFF, 16'h0000, 16'h7C02};
  int          err_count = 0;
  int          comparisons = 0;

  mbc_bcast_bank uut (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_CLK_EN(clk_en), .I_WR_EN(wr_en),
    .I_WR_ADDR(addr), .I_WR_DATA(data), .O_WR_ACK(ack), .O_WR_UNMAPPED(unm),
    .O_PRI_PERIODIC_CONTROL_BIT(p_pc), .O_PRI_PERIOD_LENGTH(p_len),
    .O_PRI_BALANCING_PAUSE_REQUEST(p_pause), .O_PRI_SYNCHRONOUS_CYCLE_BIT(p_cyc),
    .O_PRI_DUMMY_FAST_CYCLE(p_dum), .O_PRI_CELL_ENABLE(p_cell),
    .O_SEC_PERIODIC_CONTROL_BIT(s_pc), .O_SEC_PERIOD_LENGTH(s_len),
    .O_SEC_BALANCING_PAUSE_REQUEST(s_pause), .O_SEC_SYNCHRONOUS_CYCLE_BIT(s_cyc),
    .O_SEC_OVERLAP_COUNT(s_ovl), .O_SEC_FAST_MEASURE(s_fast),
    .O_SEC_CELL_ENABLE(s_cell));

  mbc_chain_model model (
    .i_clock(clk), .i_resetn(rst_n), .i_clk_en(clk_en), .i_wr_en(wr_en),
    .i_addr(addr), .i_data(data), .o_ack(m_ack), .o_unm(m_unm), .o_pc(m_pc),
    .o_len(m_len), .o_pause(m_pause), .o_cyc(m_cyc), .o_ovl(m_ovl),
    .o_fast(m_fast), .o_dummy(m_dum), .o_cell(m_cell));

  always #4 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step(input logic ce, input logic we, input logic [15:0] a,
                      input logic [15:0] d);
    @(negedge clk);
    clk_en = ce;
    wr_en  = we;
    addr   = a;
    data   = d;
  endtask

  // Bounded wait, so a missing acknowledge cannot hang the run
  task automatic wait_ack();
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(ack), 32'h1);
    if (ack !== 1'b1)
      tally_and_finish();
  endtask

  // ****************************************************************
  // Whole-port comparison, settled well clear of both clock edges
  // ****************************************************************
  always @(negedge clk)
  begin
    #2;
    chk(32'({ack, unm}), 32'({m_ack, m_unm}));
    chk(32'({p_pc, s_pc}), 32'({m_pc, m_pc}));
    chk(32'({p_len, s_len}), 32'({m_len, m_len}));
    chk(32'({p_pause, s_pause}), 32'({m_pause, m_pause}));
    chk(32'(s_ovl), 32'(m_ovl));
    chk(32'({p_dum, s_fast}), 32'({m_dum, m_fast}));
    chk(32'({p_cyc, s_cyc}), 32'({m_cyc, m_cyc}));
    chk({p_cell, s_cell}, {m_cell, m_cell});
  end

  initial
  begin
    rst_n  = 1'b0;
    clk_en = 1'b1;
    wr_en  = 1'b0;
    addr   = 16'h0000;
    data   = 16'h0000;
    r      = 32'h9E00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    step(1'b1, 1'b1, mbc_pkg::ADDR_SYNC, 16'h8003);
    step(1'b1, 1'b0, 16'h0000, 16'h0000);
    wait_ack();
    // Back to back, reserved bits set, unmapped neighbours in between
    foreach (seq_a[i])
      step(1'b1, 1'b1, seq_a[i], seq_d[i]);
    // Write held across a frozen clock enable
    step(1'b1, 1'b1, mbc_pkg::ADDR_PER, 16'h1ABC);
    repeat (3) step(1'b0, 1'b0, 16'h0000, 16'h0000);
    repeat (3) step(1'b1, 1'b0, 16'h0000, 16'h0000);
    repeat (4000)
    begin
      r = lfsr(r);
      @(negedge clk);
      // Rare mid-run reset checks the reset values again
      rst_n  = (r[15:7] != 9'h000);
      clk_en = (r[2:0] != 3'h0);
      wr_en  = r[3];
      case (r[5:4])
        2'h0: addr = mbc_pkg::ADDR_PER;
        2'h1: addr = mbc_pkg::ADDR_SYNC;
        2'h2: addr = mbc_pkg::ADDR_CELL;
        default: addr = 16'h1400 ^ {12'h000, r[9:6]};
      endcase
      data = r[31:16];
    end
    // Release in its own time step so a random reset never glitches
    @(negedge clk);
    rst_n = 1'b1;
    step(1'b1, 1'b0, 16'h0000, 16'h0000);
    repeat (4) @(negedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
